// File: verilog/sbbd_pkg.sv
// Operation
// - Addresses F00000H to F3FFFFH decode as system-bus accesses.
// - One decode term drives both bus-size-sixteen and system-bus select.
// - System-bus decoding looks at 8 processor address lines, A25..A18.
// - Bus-size-sixteen returns active on every system-bus cycle; extra terms allowed.
// - System-bus select enables the external controller and arbiter.
// - Two lowest address bits come from the four byte enables.
// - Address latches invert address bits 23..0 onto active-low bus lines.
// - High byte enable is latched with the address as bus high byte.
// - Address is latched every system-bus cycle, holding past command end.
// - Latched address drives bus only while arbiter address enable is active.
// - Inverting data path joins processor data 15..0 to 16 bus lines.
// - Write data is latched; read data is registered every clock, one clock late.
// - On writes, data enable and direction latch the data; arbiter address enable also gates the drive.
// - On reads, the local read strobe enables the transceivers.
// - Memory-mapped I/O regions issue I/O commands instead of memory commands.
// - Wait-state logic times the processor ready input.
// - Transfer acknowledge is synchronised; ready follows within two to three clocks.
// - System-bus ready lasts two clocks, extended by a registered pulse.
// - Phase clock is the processor clock divided by two.
// - Bus status outputs come from cycle type and wait states, three clocks valid.
package sbbd_pkg;
   localparam int ADDR_W = 26;
   localparam logic [7:0] WIN_MATCH = 8'h3C;
   localparam logic [ADDR_W-1:0] IO_BASE_RST = 26'h0F30000;
   localparam logic [ADDR_W-1:0] IO_MASK_RST = 26'h3FF0000;
   localparam int LOCAL_WAITS = 2;
   localparam int ADDR_HOLD_NS = 50;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic data_control_n;
      logic memory_io_n;
      logic write_read_n;
   } sbbd_cycle_type;

   typedef struct packed {
      logic ale_n;
      logic data_enable;
      logic direction;
      logic read_n;
   } sbbd_strobe_type;
endpackage

// File: verilog/sbbd_decode.sv
`timescale 1ns/100ps
`default_nettype none
module sbbd_decode #(
   parameter logic [sbbd_pkg::ADDR_W-1:0] IO_BASE = sbbd_pkg::IO_BASE_RST,
   parameter logic [sbbd_pkg::ADDR_W-1:0] IO_MASK = sbbd_pkg::IO_MASK_RST
) (
   // processor address
   input wire logic [sbbd_pkg::ADDR_W-1:2] addr,
   input wire logic [3:0] byte_enables_n,
   input wire logic extra_sixteen,
   // decode results
   output logic sysbus_hit,
   output logic io_region,
   output logic sixteen_hit,
   output logic [1:0] low_address_bits,
   output logic high_byte_enable_n
);
   logic [sbbd_pkg::ADDR_W-1:0] full_addr;

   always_comb begin
      // A25..A18 compared against one term
      sysbus_hit = (addr[25:18] == sbbd_pkg::WIN_MATCH);
      sixteen_hit = sysbus_hit | extra_sixteen;
   end

   always_comb begin
      // lowest enabled byte gives the low bits
      if (!byte_enables_n[0]) begin
         low_address_bits = 2'h0;
      end else if (!byte_enables_n[1]) begin
         low_address_bits = 2'h1;
      end else if (!byte_enables_n[2]) begin
         low_address_bits = 2'h2;
      end else begin
         low_address_bits = 2'h3;
      end
      high_byte_enable_n = byte_enables_n[1] & byte_enables_n[3];
      full_addr = {addr, low_address_bits};
      io_region = sysbus_hit && ((full_addr & IO_MASK) == IO_BASE);
   end
endmodule
`default_nettype wire

// File: verilog/sbbd_bridge.sv
`timescale 1ns/100ps
`default_nettype none
module sbbd_bridge (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // processor bus
   input wire logic [sbbd_pkg::ADDR_W-1:2] cpu_addr,
   input wire logic [3:0] byte_enables_n,
   input wire sbbd_pkg::sbbd_cycle_type cycle_type,
   input wire logic cycle_start_n,
   input wire logic extra_sixteen,
   input wire logic [15:0] cpu_data_out,
   output logic [15:0] cpu_data_in,
   output logic cpu_data_oe_n,
   output logic bus_size_sixteen_n,
   output logic ready_n,
   // controller and arbiter
   input wire sbbd_pkg::sbbd_strobe_type strobes,
   input wire logic arbiter_address_enable_n,
   output logic sysbus_select,
   output logic bus_status_zero_n,
   output logic bus_status_one_n,
   output logic io_command,
   output logic phase_clk,
   // system bus
   input wire logic transfer_ack_n,
   output logic [23:0] sysbus_address_n,
   output logic sysbus_address_oe_n,
   output logic sysbus_high_byte_n,
   input wire logic [15:0] sysbus_data_n_in,
   output logic [15:0] sysbus_data_n_out,
   output logic sysbus_data_oe_n
);
   logic hit;
   logic io_hit;
   logic sixteen;
   logic [1:0] low_bits;
   logic hbe_n;
   logic [23:0] addr_q;
   logic hbe_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic [1:0] ack_sync_q;
   logic async_ready_sync;
   logic ready_extend_pulse;
   logic ready_now_q;
   logic phase_q;
   logic first_wait_state;
   logic second_wait_state;
   logic [2:0] wait_q;
   logic s0_q;
   logic s1_q;
   logic ready_first;

   typedef enum logic [2:0] {
      IDLE = 3'b001,
      LOCAL = 3'b010,
      SYSBUS = 3'b100
   } sbbd_state_type;
   sbbd_state_type state_q;

   // wait-state decode used by the status terms
   function automatic logic at_wait(input sbbd_state_type st, input logic [2:0] w,
                                    input logic [2:0] n);
      return (st != IDLE) && (w == n);
   endfunction

   sbbd_decode u_decode (
      .addr(cpu_addr),
      .byte_enables_n(byte_enables_n),
      .extra_sixteen(extra_sixteen),
      .sysbus_hit(hit),
      .io_region(io_hit),
      .sixteen_hit(sixteen),
      .low_address_bits(low_bits),
      .high_byte_enable_n(hbe_n)
   );

   always_comb begin
      bus_size_sixteen_n = ~sixteen;
      sysbus_select = hit;
      io_command = io_hit && cycle_type.memory_io_n;
      phase_clk = phase_q;
   end

   // divide by two
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end

   // address latch captured on the controller latch strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr_q <= 24'h000000;
         hbe_q <= 1'b1;
      end else begin
         if (!strobes.ale_n && hit) begin
            addr_q <= {cpu_addr[23:2], low_bits};
            hbe_q <= hbe_n;
         end
      end
   end

   always_comb begin
      sysbus_address_n = ~addr_q;
      sysbus_high_byte_n = hbe_q;
      sysbus_address_oe_n = arbiter_address_enable_n;
   end

   // data path
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdata_q <= 16'h0000;
         rdata_q <= 16'h0000;
      end else begin
         if (strobes.data_enable && strobes.direction) begin
            wdata_q <= ~cpu_data_out;
         end
         rdata_q <= ~sysbus_data_n_in;
      end
   end

   always_comb begin
      sysbus_data_n_out = wdata_q;
      sysbus_data_oe_n = ~(hit && cycle_type.write_read_n && strobes.data_enable
                           && strobes.direction && !arbiter_address_enable_n);
      cpu_data_oe_n = ~(hit && !cycle_type.write_read_n && !strobes.read_n);
      cpu_data_in = rdata_q;
   end

   // acknowledge synchroniser
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_sync_q <= 2'h0;
      end else begin
         ack_sync_q <= {ack_sync_q[0], ~transfer_ack_n};
      end
   end
   assign async_ready_sync = ack_sync_q[1];

   // cycle tracking and wait states
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= IDLE;
         wait_q <= 3'h0;
      end else begin
         case (state_q)
            IDLE: begin
               wait_q <= 3'h0;
               if (!cycle_start_n) begin
                  state_q <= hit ? SYSBUS : LOCAL;
               end
            end
            LOCAL: begin
               wait_q <= wait_q + 3'h1;
               if (!ready_n) begin
                  state_q <= IDLE;
               end
            end
            SYSBUS: begin
               if (wait_q != 3'h7) begin
                  wait_q <= wait_q + 3'h1;
               end
               if (ready_extend_pulse) begin
                  state_q <= IDLE;
               end
            end
            default: begin
               state_q <= IDLE;
            end
         endcase
      end
   end

   always_comb begin
      first_wait_state = at_wait(state_q, wait_q, 3'h1);
      second_wait_state = at_wait(state_q, wait_q, 3'h2);
   end

   // first ready clock needs a live system cycle and phase high
   always_comb begin
      ready_first = async_ready_sync && hit && phase_q && state_q == SYSBUS;
   end

   // ready pulse and its one-cycle extension
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ready_extend_pulse <= 1'b0;
         ready_now_q <= 1'b0;
      end else begin
         ready_extend_pulse <= ready_first && !ready_extend_pulse;
         ready_now_q <= (state_q == LOCAL)
                        && (wait_q == 3'(sbbd_pkg::LOCAL_WAITS - 1));
      end
   end

   always_comb begin
      ready_n = ~((ready_first && !ready_extend_pulse)
                  || (ready_extend_pulse && hit) || ready_now_q);
   end

   // bus status held through three clocks
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s0_q <= 1'b1;
         s1_q <= 1'b1;
      end else begin
         // local cycles leave the controller status idle
         if ((state_q == IDLE && !cycle_start_n && hit)
             || (first_wait_state && state_q == SYSBUS)) begin
            s0_q <= ~cycle_type.write_read_n;
            s1_q <= cycle_type.write_read_n;
         end else if (second_wait_state || state_q == IDLE) begin
            s0_q <= 1'b1;
            s1_q <= 1'b1;
         end
      end
   end

   always_comb begin
      bus_status_zero_n = s0_q;
      bus_status_one_n = s1_q;
   end

   select_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
      sysbus_select == !bus_size_sixteen_n || extra_sixteen)
      else $error("select and size sixteen disagree");
   window_a: assert property (@(posedge ref_clk) disable iff (rst)
      sysbus_select == (cpu_addr[25:18] == sbbd_pkg::WIN_MATCH))
      else $error("window decode wrong");
   outside_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
      (cpu_addr[25:18] != sbbd_pkg::WIN_MATCH && !extra_sixteen) |-> bus_size_sixteen_n)
      else $error("size sixteen outside window");
   addr_invert_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!strobes.ale_n && hit) |=> sysbus_address_n == ~{$past(cpu_addr[23:2]), $past(low_bits)})
      else $error("address latch wrong");
   addr_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
      sysbus_address_oe_n == arbiter_address_enable_n)
      else $error("address drive without arbiter enable");
   phase_toggle_a: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst) |-> phase_clk != $past(phase_clk))
      else $error("phase clock not divided");
   ready_two_a: assert property (@(posedge ref_clk) disable iff (rst)
      ($fell(ready_n) && state_q == SYSBUS) |=> !ready_n)
      else $error("system ready not two clocks");
   ack_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
      ($fell(transfer_ack_n) && state_q == SYSBUS && hit) ##1 (hit && !transfer_ack_n)[*3]
      |-> ##[0:1] !ready_n)
      else $error("ready not within three clocks");
   low_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
      !byte_enables_n[0] |-> low_bits == 2'h0)
      else $error("low address bits wrong");
   read_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
      (hit && !cycle_type.write_read_n && !strobes.read_n) |-> !cpu_data_oe_n)
      else $error("read path not enabled");

   // latch and decode checks
   addr_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (strobes.ale_n || !hit) |=> $stable(sysbus_address_n))
      else $error("address moved without latch strobe");
   high_byte_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!strobes.ale_n && hit) |=>
         sysbus_high_byte_n == $past(byte_enables_n[1] & byte_enables_n[3]))
      else $error("high byte latch wrong");
   io_inside_a: assert property (@(posedge ref_clk) disable iff (rst)
      io_command |-> sysbus_select)
      else $error("io command outside window");

   // data path checks
   data_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
      (strobes.data_enable && strobes.direction) |=> sysbus_data_n_out == ~$past(cpu_data_out))
      else $error("write data not latched");
   read_data_a: assert property (@(posedge ref_clk) disable iff (rst)
      !$past(rst) |-> cpu_data_in == ~$past(sysbus_data_n_in))
      else $error("read data not passed");
   write_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
      !sysbus_data_oe_n |-> strobes.data_enable && !arbiter_address_enable_n)
      else $error("write drive without data enable");
   read_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
      !cpu_data_oe_n |-> !strobes.read_n && !cycle_type.write_read_n)
      else $error("read drive without read strobe");

   // timing checks
   ack_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!transfer_ack_n ##1 !transfer_ack_n) |=> async_ready_sync)
      else $error("acknowledge not synchronised");
   local_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(state_q == LOCAL) |-> ##2 !ready_n)
      else $error("local ready late");

   // status checks
   status_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(bus_status_zero_n) |=> !bus_status_zero_n)
      else $error("status zero not two clocks");
   status_one_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(bus_status_one_n) |=> !bus_status_one_n)
      else $error("status one not two clocks");
   local_status_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state_q == LOCAL) |-> bus_status_zero_n && bus_status_one_n)
      else $error("status active on local cycle");
endmodule
`default_nettype wire

// File: test/sbbd_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbbd_slave_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // command seen by the slave
   input wire logic cmd_active,
   input wire logic [3:0] wait_cyc,
   // system bus
   input wire logic [23:0] sysbus_address_n,
   input wire logic sysbus_address_oe_n,
   input wire logic [15:0] sysbus_data_n_out,
   input wire logic sysbus_data_oe_n,
   output logic transfer_ack_n,
   output logic [15:0] sysbus_data_n_in,
   output logic [15:0] last_write
);
   logic [3:0] cnt_q;
   logic [23:0] addr_q;
   always_ff @(posedge ref_clk) begin
      if (rst || !cmd_active) begin
         cnt_q <= 4'h0;
         transfer_ack_n <= 1'b1;
      end else if (cnt_q == wait_cyc) begin
         transfer_ack_n <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // address only sampled while the latches drive the bus
   always_ff @(posedge ref_clk) begin
      if (!sysbus_address_oe_n) begin
         addr_q <= ~sysbus_address_n;
      end
      if (!sysbus_data_oe_n) begin
         last_write <= ~sysbus_data_n_out;
      end
   end
   // released data lines keep changing so stale values never match
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sysbus_data_n_in <= 16'hFFFF;
      end else if (cmd_active && sysbus_data_oe_n) begin
         sysbus_data_n_in <= ~(addr_q[15:0] ^ 16'hA5C3);
      end else begin
         sysbus_data_n_in <= ~sysbus_data_n_in;
      end
   end
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [25:2] cpu_addr = 24'h000000;
   logic [3:0] byte_enables_n = 4'hF;
   sbbd_pkg::sbbd_cycle_type cycle_type = 3'h7;
   logic cycle_start_n = 1'b1;
   logic extra_sixteen = 1'b0;
   logic [15:0] cpu_data_out = 16'h0000;
   sbbd_pkg::sbbd_strobe_type strobes = 4'h9;
   logic arbiter_address_enable_n = 1'b1;
   logic cmd_active = 1'b0;
   logic [3:0] wait_cyc = 4'h1;
   logic [15:0] cpu_data_in, sysbus_data_n_in, sysbus_data_n_out, last_write;
   logic [23:0] sysbus_address_n, exp_a;
   logic cpu_data_oe_n, bus_size_sixteen_n, ready_n, sysbus_select, bus_status_zero_n;
   logic bus_status_one_n, io_command, phase_clk, transfer_ack_n, sysbus_address_oe_n;
   logic sysbus_high_byte_n, sysbus_data_oe_n, exp_h, ph;
   logic [34:0] rows [0:6];
   int fail_count = 0;
   int cmp_count = 0;
   always #5 ref_clk = ~ref_clk;
   sbbd_bridge i_sbbd_bridge (.ref_clk(ref_clk), .rst(rst), .cpu_addr(cpu_addr),
      .byte_enables_n(byte_enables_n), .cycle_type(cycle_type), .cycle_start_n(cycle_start_n),
      .extra_sixteen(extra_sixteen), .cpu_data_out(cpu_data_out), .cpu_data_in(cpu_data_in),
      .cpu_data_oe_n(cpu_data_oe_n), .bus_size_sixteen_n(bus_size_sixteen_n),
      .ready_n(ready_n), .strobes(strobes), .arbiter_address_enable_n(arbiter_address_enable_n),
      .sysbus_select(sysbus_select), .bus_status_zero_n(bus_status_zero_n),
      .bus_status_one_n(bus_status_one_n), .io_command(io_command), .phase_clk(phase_clk),
      .transfer_ack_n(transfer_ack_n), .sysbus_address_n(sysbus_address_n),
      .sysbus_address_oe_n(sysbus_address_oe_n), .sysbus_high_byte_n(sysbus_high_byte_n),
      .sysbus_data_n_in(sysbus_data_n_in), .sysbus_data_n_out(sysbus_data_n_out),
      .sysbus_data_oe_n(sysbus_data_oe_n));
   sbbd_slave_model i_sbbd_slave_model (.ref_clk(ref_clk), .rst(rst), .cmd_active(cmd_active),
      .wait_cyc(wait_cyc), .sysbus_address_n(sysbus_address_n),
      .sysbus_address_oe_n(sysbus_address_oe_n), .sysbus_data_n_out(sysbus_data_n_out),
      .sysbus_data_oe_n(sysbus_data_oe_n), .transfer_ack_n(transfer_ack_n),
      .sysbus_data_n_in(sysbus_data_n_in), .last_write(last_write));
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic bus_cycle(input logic wr, input logic [3:0] w, input logic [15:0] d);
      int n;
      cycle_type.write_read_n = wr;
      cpu_data_out = d;
      cycle_start_n = 1'b0;
      strobes.ale_n = 1'b0;
      step();
      cycle_start_n = 1'b1;
      strobes.ale_n = 1'b1;
      check(24'(bus_status_zero_n), 24'(!wr));
      check(24'(bus_status_one_n), 24'(wr));
      strobes.data_enable = wr;
      strobes.direction = wr;
      strobes.read_n = wr;
      wait_cyc = w;
      cmd_active = 1'b1;
      n = 0;
      while (transfer_ack_n !== 1'b0 && n < 40) begin
         step();
         n++;
      end
      check(24'(transfer_ack_n), 24'h0);
      n = 0;
      while (ready_n !== 1'b0 && n < 8) begin
         step();
         n++;
      end
      check(24'(n >= 2 && n <= 3), 24'h1);
      cmd_active = 1'b0;
      check(24'(sysbus_data_oe_n), 24'(!wr));
      check(24'(cpu_data_oe_n), 24'(wr));
      if (wr) check(24'(sysbus_data_n_out), {8'h00, ~d});
      else check(24'(cpu_data_in), 24'({cpu_addr[15:2], 2'h0} ^ 16'hA5C3));
      n = 0;
      while (ready_n === 1'b0 && n < 6) begin
         step();
         n++;
      end
      check(24'(n), 24'h2);
      strobes = 4'h9;
      if (wr) check(24'(last_write), 24'(d));
      repeat (sbbd_pkg::ADDR_HOLD_CYC) step();
      check(sysbus_address_n, ~{cpu_addr[23:2], 2'h0});
      step();
   endtask
   initial begin
      logic [25:0] a;
      logic [3:0] be;
      logic hit, io, hb;
      logic [1:0] lo;
      int n;
      // address, enables, window hit, io region, low bits, high byte
      rows[0] = {26'h0F00000, 4'hE, 1'b1, 1'b0, 2'h0, 1'b1};
      rows[1] = {26'h0F3FFFC, 4'h7, 1'b1, 1'b1, 2'h3, 1'b0};
      rows[2] = {26'h0F30010, 4'hC, 1'b1, 1'b1, 2'h0, 1'b0};
      rows[3] = {26'h0F40000, 4'hB, 1'b0, 1'b0, 2'h2, 1'b1};
      rows[4] = {26'h0EFFFFC, 4'hD, 1'b0, 1'b0, 2'h1, 1'b0};
      rows[5] = {26'h1F00000, 4'h3, 1'b0, 1'b0, 2'h2, 1'b0};
      rows[6] = {26'h2F00000, 4'hE, 1'b0, 1'b0, 2'h0, 1'b1};
      repeat (3) @(posedge ref_clk);
      #1;
      check(sysbus_address_n, 24'hFFFFFF);
      check(24'({sysbus_high_byte_n, bus_status_zero_n, bus_status_one_n}), 24'h7);
      check(24'({phase_clk, ready_n}), 24'h1);
      rst = 1'b0;
      exp_a = 24'hFFFFFF;
      exp_h = 1'b1;
      arbiter_address_enable_n = 1'b0;
      for (int i = 0; i < 7; i++) begin
         {a, be, hit, io, lo, hb} = rows[i];
         cpu_addr = a[25:2];
         byte_enables_n = be;
         strobes.ale_n = 1'b0;
         step();
         strobes.ale_n = 1'b1;
         check(24'(sysbus_select), 24'(hit));
         check(24'(!bus_size_sixteen_n), 24'(hit));
         check(24'(io_command), 24'(io));
         if (hit) begin
            exp_a = ~{a[23:2], lo};
            exp_h = hb;
         end
         step();
         check(sysbus_address_n, exp_a);
         check(24'(sysbus_high_byte_n), 24'(exp_h));
         check(24'(sysbus_address_oe_n), 24'h0);
      end
      extra_sixteen = 1'b1;
      step();
      check(24'({bus_size_sixteen_n, sysbus_select}), 24'h0);
      extra_sixteen = 1'b0;
      arbiter_address_enable_n = 1'b1;
      step();
      check(24'(sysbus_address_oe_n), 24'h1);
      ph = phase_clk;
      step();
      check(24'(phase_clk), 24'(!ph));
      step();
      check(24'(phase_clk), 24'(ph));
      arbiter_address_enable_n = 1'b0;
      cpu_addr = 24'h3C0040;
      byte_enables_n = 4'hC;
      step();
      bus_cycle(1'b1, 4'h1, 16'h5AF0);
      bus_cycle(1'b0, 4'h6, 16'h0000);
      bus_cycle(1'b0, 4'h1, 16'h0000);
      // local cycle outside the window
      cpu_addr = 24'h000040;
      cycle_type.write_read_n = 1'b0;
      cycle_start_n = 1'b0;
      step();
      cycle_start_n = 1'b1;
      n = 0;
      while (ready_n !== 1'b0 && n < 8) begin
         step();
         n++;
      end
      check(24'(n), 24'(sbbd_pkg::LOCAL_WAITS));
      check(24'({bus_size_sixteen_n, sysbus_select}), 24'h2);
      check(24'({bus_status_zero_n, bus_status_one_n}), 24'h3);
      step();
      check(24'(ready_n), 24'h1);
      // reset in mid-run
      rst = 1'b1;
      step();
      check(sysbus_address_n, 24'hFFFFFF);
      check(24'({sysbus_high_byte_n, bus_status_zero_n, bus_status_one_n}), 24'h7);
      check(24'({phase_clk, ready_n}), 24'h1);
      rst = 1'b0;
      step();
      check(24'(phase_clk), 24'h1);
      tally_and_finish();
   end
   initial begin
      #200000;
      fail_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
